// File: shared/trc_map.svh
// constants for the trap and reset control block
`ifndef TRC_MAP_SVH
`define TRC_MAP_SVH
`define TRC_CFG_OFFSET      8'h03
`define TRC_CFG_PRL_MSB     31
`define TRC_CFG_PRL_LSB     24
`define TRC_VEC_USER_MIN    8'h40
`define TRC_VEC_PROT        8'h05
`define TRC_VEC_RANGE       8'h02
`define TRC_VEC_UNIMP       8'h18
`define TRC_SR_FPE          8'hA0
`define TRC_SR_INTEGER_ENVIRONMENT_REG         8'hA1
`define TRC_SR_FPS          8'hA2
`define TRC_RST_ENTRY_CYC   3'h4
`define TRC_RST_EXIT_CYC    3'h4
`define TRC_PWRUP_CYC       3'h4
`define TRC_REFRESH_SLOW    9'h1FF
`define TRC_CPS_RESET       32'h0000_0870
`define TRC_BOOT_ADDR       32'h0000_0000
`endif

// File: shared/trc_pkg.sv
// types for the trap and reset control block
package trc_pkg;
  typedef enum logic [3:0] {
    TRC_REL_EQ = 4'h0,
    TRC_REL_NE = 4'h1,
    TRC_REL_LT = 4'h2,
    TRC_REL_LE = 4'h3,
    TRC_REL_GT = 4'h4,
    TRC_REL_GE = 4'h5
  } trc_rel_type;
  typedef enum logic [3:0] {
    TRC_OP_NONE   = 4'h0,
    TRC_OP_ASSERT = 4'h1,
    TRC_OP_EMUL   = 4'h2,
    TRC_OP_ADD    = 4'h3,
    TRC_OP_ADDC   = 4'h4,
    TRC_OP_ADDCS  = 4'h5,
    TRC_OP_SUB    = 4'h6,
    TRC_OP_SUBC   = 4'h7,
    TRC_OP_CMP    = 4'h8,
    TRC_OP_UNIMP  = 4'h9,
    TRC_OP_MTSR   = 4'hA,
    TRC_OP_MFSR   = 4'hB,
    TRC_OP_BRREL  = 4'hC
  } trc_op_type;
  typedef enum logic [3:0] {
    TRC_ST_PWRUP = 4'b0001,
    TRC_ST_RUN   = 4'b0010,
    TRC_ST_RESET = 4'b0100,
    TRC_ST_EXIT  = 4'b1000
  } trc_state_type;
  typedef struct packed {
    logic        valid;
    trc_op_type  op;
    trc_rel_type rel;
    logic        is_signed;
    logic        user_mode;
    logic [7:0]  vector;
    logic [7:0]  src_a;
    logic [7:0]  src_b;
    logic [7:0]  dest;
    logic [31:0] opnd_a;
    logic [31:0] opnd_b;
    logic [15:0] disp;
    logic [31:0] pc;
  } trc_instr_type;
  typedef struct packed {
    logic        trap;
    logic [7:0]  vector;
    logic        ip_load;
    logic [7:0]  ip_a;
    logic [7:0]  ip_b;
    logic [7:0]  ip_c;
    logic        res_valid;
    logic [31:0] result;
    logic        carry;
    logic        br_valid;
    logic [31:0] br_target;
  } trc_exec_type;
  typedef struct packed {
    logic        reset_mode;
    logic        cps_load;
    logic [31:0] cps_value;
    logic        cv_clear;
    logic        rom0_wide;
    logic        rom_others_off;
    logic        dram_map_off;
    logic [8:0]  refresh_interval;
    logic        dma_off;
    logic        pio_oe_clear;
    logic        par_off;
    logic        ser_off;
    logic        vid_off;
    logic        boot_fetch;
    logic [31:0] boot_addr;
  } trc_periph_type;
endpackage

// File: src/trc_trap_reset.sv
// trap raising and reset-mode sequencing for the processor core
`timescale 1ns/1ns
`default_nettype none
`include "trc_map.svh"
// Functional notes
// - assertion compares operands by relation; traps to its vector on failure
// - relations eq, ne, lt, le, gt, ge, signed or unsigned
// - user-mode failing assertion with vector below 64 becomes protection trap
// - holding assertion changes no state and raises no trap
// - emulate always traps and loads indirect pointers with its operands
// - carry add/sub use carry flag; plain and carry forms update it
// - signed add-with-carry overflow raises out-of-range trap
// - compare result boolean in msb, low 31 bits zero
// - relative branch uses 16-bit displacement; farther targets go indirect
// - float, classify, convert, multiply, divide, square_root_op all trap unexecuted
// - unimplemented op trap loads indirect pointers with register numbers
// - special register access to float/integer environment or status traps
// - configuration register: read-only 8-bit version in 31..24, rest reserved
// - reset mode entered within four clocks of reset assertion, anytime
// - reset held at power-up: enter reset after four clocks seen
// - reset mode halts execution, ignores traps, loads status, clears valid
// - first fetch to address 0 four or five clocks after release
// - reset disables dram mapping, refresh every 511 clocks
// - reset disables dma, clears request modes, idles its machines
// - reset clears pio drive enables so pins become inputs
// - reset disables parallel, serial, video; video pins become inputs
module trc_trap_reset #(
  parameter logic       REDUCED_VARIANT  = 1'b0,
  parameter logic [7:0] RELEASE_LEVEL_ID = 8'h5A  // arbitrary value
) (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // external pins
  input  wire logic                   i_reset_n,
  input  wire logic                   i_boot_width_select,
  // pipeline side
  input  wire trc_pkg::trc_instr_type i_instr,
  input  wire logic                   i_carry,
  input  wire logic [7:0]             i_sr_addr,
  output logic [31:0]                 o_sr_rdata,
  output trc_pkg::trc_exec_type       o_exec,
  // peripheral reset controls
  output trc_pkg::trc_periph_type     o_periph
);
  typedef struct packed {
    logic                  sync1;
    logic                  sync2;
    logic                  bw_sync1;
    logic                  bw_sync2;
    logic [2:0]            cnt;
    logic [2:0]            pwr_cnt;
    trc_pkg::trc_state_type st;
    logic                  strap;
    logic [31:0]           rdata;
    trc_pkg::trc_exec_type ex;
    trc_pkg::trc_periph_type pe;
  } trc_state_all_type;

  trc_state_all_type cur_ff;
  trc_state_all_type nxt_ff;

  function automatic logic rel_holds(input trc_pkg::trc_rel_type r, input logic sg,
                                     input logic [31:0] a, input logic [31:0] b);
    logic lt;
    logic eq;
    lt = sg ? ($signed(a) < $signed(b)) : (a < b);
    eq = (a == b);
    case (r)
      trc_pkg::TRC_REL_EQ: rel_holds = eq;
      trc_pkg::TRC_REL_NE: rel_holds = !eq;
      trc_pkg::TRC_REL_LT: rel_holds = lt;
      trc_pkg::TRC_REL_LE: rel_holds = lt | eq;
      trc_pkg::TRC_REL_GT: rel_holds = !(lt | eq);
      trc_pkg::TRC_REL_GE: rel_holds = !lt;
      default:             rel_holds = 1'b1;
    endcase
  endfunction

  function automatic logic [7:0] user_vec(input logic um, input logic [7:0] v);
    user_vec = (um && v < `TRC_VEC_USER_MIN) ? `TRC_VEC_PROT : v;
  endfunction

  function automatic logic virt_sr(input logic [7:0] r);
    virt_sr = (r == `TRC_SR_FPE) || (r == `TRC_SR_INTEGER_ENVIRONMENT_REG) || (r == `TRC_SR_FPS);
  endfunction

  logic        hold;
  logic [32:0] sum;
  logic        ovf;
  logic        running;
  logic [7:0]  sr_num;

  always_comb begin
    nxt_ff = cur_ff;
    hold = rel_holds(i_instr.rel, i_instr.is_signed, i_instr.opnd_a, i_instr.opnd_b);
    sum = 33'h0_0000_0000;
    ovf = 1'b0;
    nxt_ff.sync1 = i_reset_n;
    nxt_ff.sync2 = cur_ff.sync1;
    nxt_ff.bw_sync1 = i_boot_width_select;
    nxt_ff.bw_sync2 = cur_ff.bw_sync1;
    sr_num = (i_instr.op == trc_pkg::TRC_OP_MTSR) ? i_instr.dest : i_instr.src_a;
    nxt_ff.ex = '0;
    nxt_ff.pe.boot_fetch = 1'b0;
    nxt_ff.pe.cps_load = 1'b0;
    nxt_ff.pe.cv_clear = 1'b0;
    nxt_ff.rdata = (i_sr_addr == `TRC_CFG_OFFSET) ? {RELEASE_LEVEL_ID, 24'h00_0000} : 32'h0000_0000;
    running = (cur_ff.st == trc_pkg::TRC_ST_RUN);
    case (cur_ff.st)
      trc_pkg::TRC_ST_PWRUP: begin
        // power-up: wait four clocks before honouring a held reset
        if (cur_ff.pwr_cnt != `TRC_PWRUP_CYC) begin
          nxt_ff.pwr_cnt = cur_ff.pwr_cnt + 3'h1;
        end else if (!cur_ff.sync2) begin
          nxt_ff.st = trc_pkg::TRC_ST_RESET;
        end else begin
          nxt_ff.st = trc_pkg::TRC_ST_RUN;
        end
      end
      trc_pkg::TRC_ST_RUN: begin
        if (!cur_ff.sync2) begin
          nxt_ff.st = trc_pkg::TRC_ST_RESET;
        end
      end
      trc_pkg::TRC_ST_RESET: begin
        nxt_ff.cnt = 3'h0;
        if (cur_ff.sync2) begin
          nxt_ff.st = trc_pkg::TRC_ST_EXIT;
        end
      end
      trc_pkg::TRC_ST_EXIT: begin
        // synchroniser delay plus this count lands the fetch at four or five
        if (!cur_ff.sync2) begin
          nxt_ff.st = trc_pkg::TRC_ST_RESET;
        end else if (cur_ff.cnt == `TRC_RST_EXIT_CYC - 3'h3) begin
          nxt_ff.st = trc_pkg::TRC_ST_RUN;
          nxt_ff.pe.boot_fetch = 1'b1;
        end else begin
          nxt_ff.cnt = cur_ff.cnt + 3'h1;
        end
      end
      default: nxt_ff.st = trc_pkg::TRC_ST_RESET;
    endcase
    if (nxt_ff.st == trc_pkg::TRC_ST_RESET) begin
      nxt_ff.pe.reset_mode = 1'b1;
      nxt_ff.pe.cps_load = 1'b1;
      nxt_ff.pe.cps_value = `TRC_CPS_RESET;
      nxt_ff.pe.cv_clear = 1'b1;
      // strap has its own synchroniser, so the entry cycle already sees it
      nxt_ff.strap = REDUCED_VARIANT ? 1'b0 : cur_ff.bw_sync2;
      nxt_ff.pe.rom0_wide = nxt_ff.strap;
      nxt_ff.pe.rom_others_off = 1'b1;
      nxt_ff.pe.dram_map_off = 1'b1;
      nxt_ff.pe.refresh_interval = `TRC_REFRESH_SLOW;
      nxt_ff.pe.dma_off = 1'b1;
      nxt_ff.pe.pio_oe_clear = 1'b1;
      nxt_ff.pe.par_off = 1'b1;
      nxt_ff.pe.ser_off = 1'b1;
      nxt_ff.pe.vid_off = 1'b1;
      nxt_ff.pe.boot_addr = `TRC_BOOT_ADDR;
    end else if (nxt_ff.st == trc_pkg::TRC_ST_RUN) begin
      // peripheral disables hold through reset mode and clear on entering run; software reconfigures them afterwards
      nxt_ff.pe.reset_mode = 1'b0;
      nxt_ff.pe.rom_others_off = 1'b0;
      nxt_ff.pe.dram_map_off = 1'b0;
      nxt_ff.pe.dma_off = 1'b0;
      nxt_ff.pe.pio_oe_clear = 1'b0;
      nxt_ff.pe.par_off = 1'b0;
      nxt_ff.pe.ser_off = 1'b0;
      nxt_ff.pe.vid_off = 1'b0;
    end
    // traps ignored outside run state
    if (running && i_instr.valid) begin
      case (i_instr.op)
        trc_pkg::TRC_OP_ASSERT: begin
          if (!hold) begin
            nxt_ff.ex.trap = 1'b1;
            nxt_ff.ex.vector = user_vec(i_instr.user_mode, i_instr.vector);
          end
        end
        trc_pkg::TRC_OP_EMUL: begin
          nxt_ff.ex.trap = 1'b1;
          nxt_ff.ex.vector = user_vec(i_instr.user_mode, i_instr.vector);
          nxt_ff.ex.ip_load = 1'b1;
          nxt_ff.ex.ip_a = i_instr.src_a;
          nxt_ff.ex.ip_b = i_instr.src_b;
          nxt_ff.ex.ip_c = i_instr.dest;
        end
        trc_pkg::TRC_OP_ADD, trc_pkg::TRC_OP_ADDC, trc_pkg::TRC_OP_ADDCS: begin
          sum = {1'b0, i_instr.opnd_a} + {1'b0, i_instr.opnd_b} +
                {32'h0000_0000, (i_instr.op != trc_pkg::TRC_OP_ADD) & i_carry};
          ovf = (i_instr.opnd_a[31] == i_instr.opnd_b[31]) && (sum[31] != i_instr.opnd_a[31]);
          nxt_ff.ex.res_valid = 1'b1;
          nxt_ff.ex.result = sum[31:0];
          nxt_ff.ex.carry = sum[32];
          if (i_instr.op == trc_pkg::TRC_OP_ADDCS && ovf) begin
            nxt_ff.ex.trap = 1'b1;
            nxt_ff.ex.vector = `TRC_VEC_RANGE;
          end
        end
        trc_pkg::TRC_OP_SUB, trc_pkg::TRC_OP_SUBC: begin
          // carry set means no borrow
          sum = {1'b0, i_instr.opnd_a} + {1'b0, ~i_instr.opnd_b} +
                {32'h0000_0000, (i_instr.op == trc_pkg::TRC_OP_SUB) | i_carry};
          nxt_ff.ex.res_valid = 1'b1;
          nxt_ff.ex.result = sum[31:0];
          nxt_ff.ex.carry = sum[32];
        end
        trc_pkg::TRC_OP_CMP: begin
          nxt_ff.ex.res_valid = 1'b1;
          nxt_ff.ex.result = {hold, 31'h0000_0000};
        end
        trc_pkg::TRC_OP_BRREL: begin
          nxt_ff.ex.br_valid = 1'b1;
          nxt_ff.ex.br_target = i_instr.pc + {{14{i_instr.disp[15]}}, i_instr.disp, 2'b00};
        end
        trc_pkg::TRC_OP_UNIMP: begin
          nxt_ff.ex.trap = 1'b1;
          nxt_ff.ex.vector = `TRC_VEC_UNIMP;
          nxt_ff.ex.ip_load = 1'b1;
          nxt_ff.ex.ip_a = i_instr.src_a;
          nxt_ff.ex.ip_b = i_instr.src_b;
          nxt_ff.ex.ip_c = i_instr.dest;
        end
        trc_pkg::TRC_OP_MTSR, trc_pkg::TRC_OP_MFSR: begin
          if (virt_sr(sr_num)) begin
            nxt_ff.ex.trap = 1'b1;
            nxt_ff.ex.vector = `TRC_VEC_PROT;
          end
        end
        default: nxt_ff.ex = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cur_ff <= '0;
      cur_ff.st <= trc_pkg::TRC_ST_PWRUP;
      cur_ff.sync1 <= 1'b1;
      cur_ff.sync2 <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign o_exec = cur_ff.ex;
  assign o_periph = cur_ff.pe;
  assign o_sr_rdata = cur_ff.rdata;

  sequence reset_low_s;
    !i_reset_n;
  endsequence

  reset_entry_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (cur_ff.st == trc_pkg::TRC_ST_RUN) ##0 reset_low_s [*3] |=> o_periph.reset_mode)
    else $error("reset mode not entered in time");
  no_trap_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_periph.reset_mode |=> !o_exec.trap)
    else $error("trap raised in reset mode");
  assert_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (running && i_instr.valid && i_instr.op == trc_pkg::TRC_OP_ASSERT && hold) |=> !o_exec.trap && !o_exec.res_valid)
    else $error("holding assertion had effect");
  user_vec_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (running && i_instr.valid && i_instr.op == trc_pkg::TRC_OP_ASSERT && !hold && i_instr.user_mode
     && i_instr.vector < 8'h40) |=> o_exec.trap && o_exec.vector == `TRC_VEC_PROT)
    else $error("user vector not protected");
  emul_trap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (running && i_instr.valid && i_instr.op == trc_pkg::TRC_OP_EMUL) |=> o_exec.trap && o_exec.ip_load)
    else $error("emulate did not trap");
  unimp_trap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (running && i_instr.valid && i_instr.op == trc_pkg::TRC_OP_UNIMP) |=> o_exec.trap && !o_exec.res_valid)
    else $error("unimplemented op executed");
  cmp_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_exec.res_valid && $past(i_instr.op) == trc_pkg::TRC_OP_CMP |-> o_exec.result[30:0] == 31'h0)
    else $error("compare low bits not zero");
  boot_fetch_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(cur_ff.sync2) && cur_ff.st == trc_pkg::TRC_ST_RESET ##1 i_reset_n [*3] |-> ##[0:2] o_periph.boot_fetch)
    else $error("boot fetch late");
  sr_virtual_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (running && i_instr.valid && (i_instr.op == trc_pkg::TRC_OP_MTSR || i_instr.op == trc_pkg::TRC_OP_MFSR)
     && virt_sr(sr_num)) |=> o_exec.trap && o_exec.vector == `TRC_VEC_PROT)
    else $error("virtual register access did not trap");
  range_trap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (running && i_instr.valid && i_instr.op == trc_pkg::TRC_OP_ADDCS && ovf) |=> o_exec.trap
     && o_exec.vector == `TRC_VEC_RANGE)
    else $error("signed overflow did not trap");
  cfg_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_sr_addr == `TRC_CFG_OFFSET) |=> o_sr_rdata == {RELEASE_LEVEL_ID, 24'h00_0000})
    else $error("configuration read wrong");
  pwrup_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (cur_ff.st == trc_pkg::TRC_ST_PWRUP && cur_ff.pwr_cnt != `TRC_PWRUP_CYC) |=> !o_periph.reset_mode)
    else $error("reset mode entered before power-up count");
  dram_slow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_periph.reset_mode |-> o_periph.dram_map_off && o_periph.refresh_interval == `TRC_REFRESH_SLOW)
    else $error("dram not slowed in reset");
  dma_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_periph.reset_mode |-> o_periph.dma_off)
    else $error("dma not disabled in reset");
  pio_input_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_periph.reset_mode |-> o_periph.pio_oe_clear)
    else $error("pio drive not cleared in reset");
  port_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_periph.reset_mode |-> o_periph.par_off && o_periph.ser_off && o_periph.vid_off)
    else $error("ports not disabled in reset");
endmodule
`default_nettype wire

// File: verif/trc_boot_partner.sv
// reset source and boot bank model facing the trap and reset block
`timescale 1ns/1ns
`default_nettype none
`include "trc_map.svh"
module trc_boot_partner (
  // clock and request
  input  wire logic                    i_clk,
  input  wire logic                    i_assert,
  // device side
  input  wire trc_pkg::trc_periph_type i_periph,
  output logic                         o_reset_n,
  output logic                         o_boot_hit
);
  logic       low_ff = 1'b1;
  logic [1:0] cnt_ff = 2'h0;
  // a short request still gives four low clocks
  always_ff @(posedge i_clk) begin
    if (i_assert) begin
      low_ff <= 1'b1;
      cnt_ff <= 2'h0;
    end else if (cnt_ff != 2'h3) begin
      cnt_ff <= cnt_ff + 2'h1;
    end else begin
      low_ff <= 1'b0;
    end
  end
  assign o_reset_n = ~low_ff;
  // bank 0 answers only the boot address
  assign o_boot_hit = i_periph.boot_fetch && (i_periph.boot_addr == `TRC_BOOT_ADDR);
endmodule
`default_nettype wire

// File: verif/test_trc_trap_reset.sv
// self-checking bench for the trap and reset control block
`timescale 1ns/1ns
`default_nettype none
`include "trc_map.svh"
module test_trc_trap_reset;
  localparam logic [7:0] LEVEL = 8'h3C;  // arbitrary value
  logic                    i_clk = 1'b0;
  logic                    i_rst = 1'b1;
  logic                    rst_req = 1'b1;
  logic                    bw = 1'b1;
  trc_pkg::trc_instr_type  instr = '0;
  logic                    carry = 1'b0;
  logic [7:0]              sr_addr = 8'h00;
  logic [31:0]             sr_rdata;
  trc_pkg::trc_exec_type   ex;
  trc_pkg::trc_periph_type per;
  logic                    rst_n;
  logic                    boot_hit;
  int                      num_errors = 0;
  int                      check_count = 0;
  logic [31:0]             seed = 32'h8871;
  int                      n;
  always #2 i_clk = ~i_clk;
  trc_trap_reset #(.RELEASE_LEVEL_ID(LEVEL)) u_trc_trap_reset (.i_clk(i_clk), .i_rst(i_rst), .i_reset_n(rst_n),
    .i_boot_width_select(bw), .i_instr(instr), .i_carry(carry), .i_sr_addr(sr_addr), .o_sr_rdata(sr_rdata),
    .o_exec(ex), .o_periph(per));
  trc_boot_partner u_trc_boot_partner (.i_clk(i_clk), .i_assert(rst_req), .i_periph(per), .o_reset_n(rst_n),
    .o_boot_hit(boot_hit));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // a wait that runs out ends the run
  task automatic limit(input int k);
    if (k >= 12) begin
      num_errors++;
      stop_test();
    end
  endtask
  function automatic logic rel_ok(input trc_pkg::trc_instr_type t);
    logic signed [32:0] a;
    logic signed [32:0] b;
    a = {t.is_signed & t.opnd_a[31], t.opnd_a};
    b = {t.is_signed & t.opnd_b[31], t.opnd_b};
    case (t.rel)
      trc_pkg::TRC_REL_EQ: return a == b;
      trc_pkg::TRC_REL_NE: return a != b;
      trc_pkg::TRC_REL_LT: return a < b;
      trc_pkg::TRC_REL_LE: return a <= b;
      trc_pkg::TRC_REL_GT: return a > b;
      default: return a >= b;
    endcase
  endfunction
  // reference model of one instruction, compared one cycle after issue
  task automatic run_instr(input trc_pkg::trc_instr_type t);
    logic        c;
    logic        ok;
    logic        bad;
    logic [7:0]  v;
    logic [7:0]  sr;
    logic [31:0] bb;
    logic [32:0] s;
    bb = rnd();
    c = bb[0];
    @(posedge i_clk);
    instr <= t;
    carry <= c;
    @(posedge i_clk);
    instr.valid <= 1'b0;
    #1;
    ok = rel_ok(t);
    v = (t.user_mode && t.vector < `TRC_VEC_USER_MIN) ? `TRC_VEC_PROT : t.vector;
    bad = t.op == trc_pkg::TRC_OP_SUB || t.op == trc_pkg::TRC_OP_SUBC;
    bb = bad ? ~t.opnd_b : t.opnd_b;
    s = {1'b0, t.opnd_a} + {1'b0, bb} + 33'(t.op == trc_pkg::TRC_OP_ADD ? 1'b0 : bad && !t.op[0] ? 1'b1 : c);
    case (t.op)
      trc_pkg::TRC_OP_ASSERT: begin
        chk("trap", ex.trap, !ok);
        if (!ok) chk("vector", ex.vector, v);
      end
      trc_pkg::TRC_OP_EMUL: chk("emul", {ex.trap, ex.vector, ex.ip_load, ex.ip_a, ex.ip_b},
        {1'b1, v, 1'b1, t.src_a, t.src_b});
      trc_pkg::TRC_OP_CMP: chk("cmp", {ex.res_valid, ex.result}, {1'b1, ok, 31'h0});
      trc_pkg::TRC_OP_UNIMP: chk("unimp", {ex.trap, ex.vector, ex.ip_load, ex.ip_a, ex.ip_b, ex.ip_c},
        {1'b1, `TRC_VEC_UNIMP, 1'b1, t.src_a, t.src_b, t.dest});
      trc_pkg::TRC_OP_MTSR, trc_pkg::TRC_OP_MFSR: begin
        sr = t.op == trc_pkg::TRC_OP_MTSR ? t.dest : t.src_a;
        bad = sr >= `TRC_SR_FPE && sr <= `TRC_SR_FPS;
        chk("sr_trap", {ex.trap, bad ? ex.vector : 8'h00}, {bad, bad ? `TRC_VEC_PROT : 8'h00});
      end
      trc_pkg::TRC_OP_BRREL: chk("branch", {ex.br_valid, ex.br_target},
        {1'b1, t.pc + {{14{t.disp[15]}}, t.disp, 2'b00}});
      default: begin
        bad = t.op == trc_pkg::TRC_OP_ADDCS && t.opnd_a[31] == bb[31] && s[31] != t.opnd_a[31];
        chk("range", {ex.trap, bad ? ex.vector : 8'h00}, {bad, bad ? `TRC_VEC_RANGE : 8'h00});
        if (!bad) chk("sum", {ex.res_valid, ex.carry, ex.result}, {1'b1, s});
      end
    endcase
  endtask
  // reset values, traps ignored, then boot fetch after release
  task automatic reset_phase(input logic w);
    trc_pkg::trc_instr_type t;
    t = '0;
    t.valid = 1'b1;
    t.op = trc_pkg::TRC_OP_ASSERT;
    t.opnd_b = 32'h0000_0001;
    t.vector = 8'h80;
    chk("periph", {per.reset_mode, per.cps_load, per.cv_clear, per.rom_others_off, per.dram_map_off, per.dma_off,
      per.pio_oe_clear, per.par_off, per.ser_off, per.vid_off}, 10'h3FF);
    chk("cps", per.cps_value, `TRC_CPS_RESET);
    chk("refresh", per.refresh_interval, `TRC_REFRESH_SLOW);
    chk("wide", per.rom0_wide, w);
    @(posedge i_clk);
    instr <= t;
    @(posedge i_clk);
    instr.valid <= 1'b0;
    #1;
    chk("held", ex.trap, 1'b0);
    @(posedge i_clk);
    rst_req <= 1'b0;
    for (n = 0; n < 12 && rst_n !== 1'b1; n++) tick();
    limit(n);
    for (n = 0; n < 12 && per.boot_fetch !== 1'b1; n++) tick();
    limit(n);
    chk("boot_lat", n == 4 || n == 5, 1'b1);
    chk("boot", {boot_hit, per.reset_mode}, 2'b10);
    tick();
  endtask
  initial begin
    trc_pkg::trc_instr_type t;
    logic [31:0]            r;
    logic [31:0]            q;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    // pin low at power-up: no reset mode before four clocks
    for (n = 0; n < 12 && per.reset_mode !== 1'b1; n++) begin
      tick();
      if (n < 4) chk("pwrup", per.reset_mode, 1'b0);
    end
    limit(n);
    reset_phase(1'b1);
    for (int i = 0; i < 160; i++) begin
      r = rnd();
      q = rnd();
      t = '0;
      t.valid = 1'b1;
      t.op = trc_pkg::trc_op_type'(4'h1 + 4'(r % 12));
      t.rel = trc_pkg::trc_rel_type'(4'(r[7:4] % 6));
      t.is_signed = r[8];
      t.user_mode = r[9];
      t.vector = r[13] ? 8'h3F + 8'(r[14]) : q[7:0];
      t.src_a = r[11:10] == 2'h3 ? `TRC_CFG_OFFSET : `TRC_SR_FPE + 8'(r[11:10]);
      t.src_b = q[15:8];
      t.dest = q[17:16] == 2'h3 ? q[23:16] : `TRC_SR_FPE + 8'(q[17:16]);
      t.opnd_a = rnd();
      t.opnd_b = r[12] ? t.opnd_a : rnd();
      t.disp = r[31:16];
      t.pc = {q[31:2], 2'b00};
      run_instr(t);
    end
    @(posedge i_clk);
    sr_addr <= `TRC_CFG_OFFSET;
    tick();
    tick();
    chk("cfg", sr_rdata, {LEVEL, 24'h0});
    @(posedge i_clk);
    sr_addr <= 8'h04;
    tick();
    tick();
    chk("unmapped", sr_rdata, 32'h0);
    // reset in mid-run with the narrow boot strap
    @(posedge i_clk);
    bw <= 1'b0;
    rst_req <= 1'b1;
    // pin stays low until the reset phase lets it go, so exit timing is measured from release
    for (n = 0; n < 12 && per.reset_mode !== 1'b1; n++) tick();
    limit(n);
    chk("entry", n <= 4, 1'b1);
    reset_phase(1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
